// ---- inc/conv_sup_pkg.sv ----
// Purpose: Shared constants and types for the converter supervisor
// Assumes: 100 MHz core clock, synchronous active-high reset
// Notes: Fault sources are indexed by the IDX_OUT_OV..IDX_OT constants
package conv_sup_pkg;
   localparam int NUM_COND = 6;
   localparam int VW = 12;
   localparam int CW = 12;
   localparam int TW = 10;
   localparam int DLYW = 16;
   localparam int FLTW = 4;
   // Condition indices
   localparam int IDX_OUT_OV = 0;
   localparam int IDX_OUT_UV = 1;
   localparam int IDX_IN_OV = 2;
   localparam int IDX_IN_UV = 3;
   localparam int IDX_OC = 4;
   localparam int IDX_OT = 5;
   localparam logic [2:0] RETRY_HICCUP = 3'h7;
   localparam logic [2:0] RETRY_RST = 3'h0;
   localparam logic [DLYW-1:0] DELAY_RST = 16'h0000;
   localparam int RETRY_FACTOR = 100;
   // Delay unit: 1 us expressed in ns, converted to core cycles
   localparam int DLY_UNIT_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int DLY_UNIT_CYC = (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_SHIFT = 3;
   localparam logic [5:0] ALERT_MASK_RST = 6'h00;
   localparam logic FEATURE_TRACK_RST = 1'b0;
   localparam logic [1:0] SYNC_MODE_RST = 2'h0;
   // Temperature range limits in degrees C, signed
   localparam logic signed [TW-1:0] TEMP_MIN = -10'sd40;
   localparam logic signed [TW-1:0] TEMP_MAX = 10'sd150;

   typedef enum logic [1:0] {
      SYNC_OFF = 2'b00,
      SYNC_IN = 2'b01,
      SYNC_OUT = 2'b10
   } sync_mode_t;

   typedef struct packed {
      logic [DLYW-1:0] delay_to_fault;
      logic [DLYW-1:0] delay_to_retry;
      logic [2:0] retry_limit;
      logic soft_off;
   } fault_cfg_t;

   typedef struct packed {
      logic hs_on_n;
      logic ls_on_n;
      logic hiz;
   } stage_ctl_t;
endpackage : conv_sup_pkg

// ---- rtl/cur_filter.sv ----
// Purpose: Moving average of current samples for telemetry and warnings
// Assumes: Samples arrive on sample_vld from same clock domain
// Notes: First-order IIR, shift sets time constant
`timescale 1ns/10ps
module cur_filter
   import conv_sup_pkg::*;
#(
   parameter int W = CW
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic sample_vld,
   input wire logic [W-1:0] sample,
   output logic [W-1:0] avg_q
);
   logic [W+FILT_SHIFT-1:0] acc_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_q <= '0;
      end else if (clk_en && sample_vld) begin
         acc_q <= acc_q - (acc_q >> FILT_SHIFT) + {{FILT_SHIFT{1'b0}}, sample};
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         avg_q <= '0;
      end else if (clk_en) begin
         avg_q <= acc_q[W+FILT_SHIFT-1:FILT_SHIFT];
      end
   end
endmodule : cur_filter

// ---- rtl/fault_chan.sv ----
// Purpose: Per-condition delay-to-fault, response launch and retry counting
// Assumes: cond is already synchronised or same-domain
// Notes: Latched off until enable falls; en_fall clears the latch
`timescale 1ns/10ps
module fault_chan
   import conv_sup_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic tick,
   input wire logic cond,
   input wire logic is_fault,
   input wire fault_cfg_t cfg,
   input wire logic en_fall,
   output logic trip_q,
   output logic latched_q,
   output logic flag_set
);
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_DLY = 2'b01,
      CH_TRIP = 2'b10,
      CH_LATCH = 2'b11
   } ch_state_t;

   ch_state_t st_q;
   logic [DLYW+7-1:0] cnt_q;
   logic [2:0] tries_q;
   logic [DLYW+7-1:0] retry_dly;

   // Retry delay derives from the fault delay when that is non-zero
   always_comb begin
      if (cfg.delay_to_fault != DELAY_RST) begin
         retry_dly = (DLYW+7)'(cfg.delay_to_fault) * (DLYW+7)'(RETRY_FACTOR);
      end else begin
         retry_dly = (DLYW+7)'(cfg.delay_to_retry);
      end
   end

   assign flag_set = clk_en && cond;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= CH_IDLE;
         cnt_q <= '0;
         tries_q <= RETRY_RST;
         trip_q <= 1'b0;
         latched_q <= 1'b0;
      end else if (clk_en) begin
         case (st_q)
            CH_IDLE: begin
               if (cond && is_fault) begin
                  if (cfg.delay_to_fault == DELAY_RST) begin
                     st_q <= CH_TRIP;
                     trip_q <= 1'b1;
                     cnt_q <= retry_dly;
                  end else begin
                     st_q <= CH_DLY;
                     cnt_q <= (DLYW+7)'(cfg.delay_to_fault);
                  end
               end
            end
            CH_DLY: begin
               if (tick) begin
                  if (cnt_q > (DLYW+7)'(1)) begin
                     cnt_q <= cnt_q - (DLYW+7)'(1);
                  end else if (cond) begin
                     st_q <= CH_TRIP;
                     trip_q <= 1'b1;
                     cnt_q <= retry_dly;
                  end else begin
                     st_q <= CH_IDLE;
                  end
               end
            end
            CH_TRIP: begin
               if (cfg.retry_limit != RETRY_HICCUP && tries_q >= cfg.retry_limit) begin
                  st_q <= CH_LATCH;
                  latched_q <= 1'b1;
               end else if (tick) begin
                  if (cnt_q > (DLYW+7)'(1)) begin
                     cnt_q <= cnt_q - (DLYW+7)'(1);
                  end else begin
                     trip_q <= 1'b0;
                     st_q <= CH_IDLE;
                     if (cond) begin
                        tries_q <= (cfg.retry_limit == RETRY_HICCUP) ? tries_q :
                           tries_q + 3'h1;
                     end else begin
                        tries_q <= RETRY_RST;
                     end
                  end
               end
            end
            CH_LATCH: begin
               if (en_fall) begin
                  st_q <= CH_IDLE;
                  trip_q <= 1'b0;
                  latched_q <= 1'b0;
                  tries_q <= RETRY_RST;
               end
            end
            default: st_q <= CH_IDLE;
         endcase
      end
   end

   chk_latch_holds_trip: assert property (@(posedge core_clk) disable iff (rst)
      latched_q |-> trip_q) else $error("latched without trip");
   chk_zero_delay_trip: assert property (@(posedge core_clk) disable iff (rst)
      (clk_en && st_q == CH_IDLE && cond && is_fault && cfg.delay_to_fault == DELAY_RST)
      |=> trip_q) else $error("zero delay fault did not trip");
   chk_warn_no_trip: assert property (@(posedge core_clk) disable iff (rst)
      $rose(trip_q) |-> $past(cond) && $past(is_fault)) else $error("trip without fault");
endmodule : fault_chan

// ---- rtl/conv_supervisor.sv ----
// Purpose: Set point selection, fault classification and shutdown control
// Assumes: Analog pins arrive as sampled codes; enable pin is asynchronous
// Notes: Faults with soft_off set in fault_cfg use soft-off, all other faults go high impedance
`timescale 1ns/10ps

// Functional notes
// - Target is minimum of programmed setting and tracking input.
// - Tracking off after reset; enabled by feature control command.
// - With tracking enabled, tracking input overrides prebias off level.
// - Sync pin direction chosen by pin configuration command; off by default.
// - Report controller and combined power-train temperature, -40 to 150 C.
// - Current averaged before telemetry and warning compare.
// - Over-current compares raw unfiltered samples.
// - Warnings set flags only; faults set flag and launch response.
// - Alert output maskable per condition.
// - Over-temperature fault ramps output down at fall slew rate.
// - Soft-off stops at prebias off level.
// - Other faults switch both power switches off immediately.
// - Non-zero fault delay: wait, re-check, respond only if persisting.
// - Non-zero retry delay: wait, restart, re-respond if fault persists.
// - Non-zero fault delay makes retry delay 100 times fault delay.
// - Retry count 0..6 restarts; seven means unlimited hiccup.
// - Defaults: zero delay and latch off.
// - Latched fault cleared by enable pin low then high; cleared here already on the enable falling edge (en_fall).
// - Disable with non-zero off level ramps to level then tristates.
module conv_supervisor
   import conv_sup_pkg::*;
#(
   parameter int RAMP_STEP_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic enable_pin,
   input wire logic [VW-1:0] vout_setting,
   input wire logic [VW-1:0] tracking_input,
   input wire logic [VW-1:0] prebias_off_level,
   input wire logic [RAMP_STEP_W-1:0] fall_step,
   input wire logic feature_control_command,
   input wire logic [1:0] pin_configuration_command,
   input wire logic cmd_strobe,
   input wire logic [CW-1:0] iout_sample,
   input wire logic iout_vld,
   input wire logic [CW-1:0] oc_fault_limit,
   input wire logic [CW-1:0] oc_warn_limit,
   input wire logic signed [TW-1:0] ctrl_temp,
   input wire logic signed [TW-1:0] pt_temp_a,
   input wire logic signed [TW-1:0] pt_temp_b,
   input wire logic signed [TW-1:0] ot_fault_limit,
   input wire logic [3:0] cmp_fault,
   input wire logic [NUM_COND-1:0] cmp_warn,
   input wire logic [NUM_COND-1:0] alert_mask,
   input wire fault_cfg_t [NUM_COND-1:0] fault_cfg,
   input wire logic status_clear,
   output logic [VW-1:0] target_q,
   output stage_ctl_t stage_q,
   output logic [1:0] sync_dir_q,
   output logic signed [TW-1:0] temp_ctrl_q,
   output logic signed [TW-1:0] temp_pt_q,
   output logic [CW-1:0] iout_avg_q,
   output logic [NUM_COND-1:0] status_q,
   output logic alert_n_q,
   output logic latched_off_q
);
   typedef enum logic [1:0] {
      OP_OFF = 2'b00,
      OP_RUN = 2'b01,
      OP_RAMP = 2'b10,
      OP_HIZ = 2'b11
   } op_state_t;

   op_state_t op_q;
   logic en_s1_q;
   logic en_s2_q;
   logic en_d_q;
   logic track_en_q;
   logic [VW-1:0] ramp_q;
   logic [15:0] tick_cnt_q;
   logic tick;
   logic [CW-1:0] iout_avg;
   logic [NUM_COND-1:0] cond;
   logic [NUM_COND-1:0] flag_set;
   logic [NUM_COND-1:0] trip;
   logic [NUM_COND-1:0] latched;
   logic [VW-1:0] track_pt;
   logic hard_trip;
   logic soft_trip;
   logic en_fall;
   logic signed [TW:0] pt_sum;
   logic [VW-1:0] off_level;

   // Enable pin is asynchronous: two stages before use
   always_ff @(posedge core_clk) begin
      if (rst) begin
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
         en_d_q <= 1'b0;
      end else if (clk_en) begin
         en_s1_q <= enable_pin;
         en_s2_q <= en_s1_q;
         en_d_q <= en_s2_q;
      end
   end
   assign en_fall = en_d_q && !en_s2_q;

   // Delay timebase for fault and retry timing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_cnt_q <= '0;
      end else if (clk_en) begin
         if (tick_cnt_q == 16'(DLY_UNIT_CYC - 1)) begin
            tick_cnt_q <= '0;
         end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
         end
      end
   end
   assign tick = (tick_cnt_q == 16'(DLY_UNIT_CYC - 1));

   // Management commands
   always_ff @(posedge core_clk) begin
      if (rst) begin
         track_en_q <= FEATURE_TRACK_RST;
         sync_dir_q <= SYNC_MODE_RST;
      end else if (clk_en && cmd_strobe) begin
         track_en_q <= feature_control_command;
         sync_dir_q <= pin_configuration_command;
      end
   end

   // Averaged current for telemetry and warnings only
   cur_filter #(
      .W(CW)
   ) u_filt (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .sample_vld(iout_vld),
      .sample(iout_sample),
      .avg_q(iout_avg)
   );

   assign pt_sum = (TW+1)'(pt_temp_a) + (TW+1)'(pt_temp_b);

   // Temperature telemetry, clamped to the sensing range
   always_ff @(posedge core_clk) begin
      if (rst) begin
         temp_ctrl_q <= '0;
         temp_pt_q <= '0;
         iout_avg_q <= '0;
      end else if (clk_en) begin
         temp_ctrl_q <= (ctrl_temp < TEMP_MIN) ? TEMP_MIN :
            (ctrl_temp > TEMP_MAX) ? TEMP_MAX : ctrl_temp;
         temp_pt_q <= (pt_sum < (TW+1)'(TEMP_MIN)) ? TEMP_MIN :
            (pt_sum > (TW+1)'(TEMP_MAX)) ? TEMP_MAX : pt_sum[TW-1:0];
         iout_avg_q <= iout_avg;
      end
   end

   // Fault conditions; raw sample feeds over-current so filter lag is avoided
   always_comb begin
      cond = '0;
      cond[IDX_OUT_OV] = cmp_fault[0];
      cond[IDX_OUT_UV] = cmp_fault[1];
      cond[IDX_IN_OV] = cmp_fault[2];
      cond[IDX_IN_UV] = cmp_fault[3];
      cond[IDX_OC] = iout_vld && (iout_sample > oc_fault_limit);
      cond[IDX_OT] = (ctrl_temp > ot_fault_limit) || (temp_pt_q > ot_fault_limit);
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_COND; gi++) begin : g_chan
         fault_chan u_chan (
            .core_clk(core_clk),
            .rst(rst),
            .clk_en(clk_en),
            .tick(tick),
            .cond(cond[gi]),
            .is_fault(1'b1),
            .cfg(fault_cfg[gi]),
            .en_fall(en_fall),
            .trip_q(trip[gi]),
            .latched_q(latched[gi]),
            .flag_set(flag_set[gi])
         );
      end
   endgenerate

   // Status flags: warnings and faults both set; set wins over clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_q <= '0;
      end else if (clk_en) begin
         status_q <= (status_clear ? '0 : status_q) | flag_set | cmp_warn
            | {NUM_COND{1'b0}} | ((iout_avg > oc_warn_limit) ?
            NUM_COND'(1) << IDX_OC : '0);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         alert_n_q <= 1'b1;
      end else if (clk_en) begin
         alert_n_q <= ~|(status_q & ~alert_mask);
      end
   end

   always_comb begin
      hard_trip = 1'b0;
      soft_trip = 1'b0;
      for (int i = 0; i < NUM_COND; i++) begin
         if (trip[i] && fault_cfg[i].soft_off) begin
            soft_trip = 1'b1;
         end else if (trip[i]) begin
            hard_trip = 1'b1;
         end
      end
   end

   assign track_pt = (tracking_input < vout_setting) ? tracking_input : vout_setting;
   // Tracking wins over the prebias floor
   assign off_level = track_en_q ? '0 : prebias_off_level;

   // Output sequencing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         op_q <= OP_OFF;
         ramp_q <= '0;
         stage_q <= '{hs_on_n: 1'b1, ls_on_n: 1'b1, hiz: 1'b1};
         target_q <= '0;
         latched_off_q <= 1'b0;
      end else if (clk_en) begin
         latched_off_q <= |latched;
         case (op_q)
            OP_OFF: begin
               stage_q <= '{hs_on_n: 1'b1, ls_on_n: 1'b1, hiz: 1'b1};
               target_q <= '0;
               if (en_s2_q && !(|trip)) begin
                  op_q <= OP_RUN;
               end
            end
            OP_RUN: begin
               stage_q <= '{hs_on_n: 1'b0, ls_on_n: 1'b0, hiz: 1'b0};
               target_q <= track_en_q ? track_pt : vout_setting;
               ramp_q <= track_en_q ? track_pt : vout_setting;
               if (hard_trip) begin
                  op_q <= OP_HIZ;
                  stage_q <= '{hs_on_n: 1'b1, ls_on_n: 1'b1, hiz: 1'b1};
               end else if (soft_trip || !en_s2_q) begin
                  op_q <= OP_RAMP;
               end
            end
            OP_RAMP: begin
               if (hard_trip) begin
                  op_q <= OP_HIZ;
                  stage_q <= '{hs_on_n: 1'b1, ls_on_n: 1'b1, hiz: 1'b1};
               end else if (track_en_q && en_s2_q && !soft_trip) begin
                  target_q <= track_pt;
               end else if (ramp_q > off_level + VW'(fall_step)) begin
                  ramp_q <= ramp_q - VW'(fall_step);
                  target_q <= ramp_q - VW'(fall_step);
               end else begin
                  target_q <= off_level;
                  op_q <= OP_HIZ;
                  stage_q <= '{hs_on_n: 1'b1, ls_on_n: 1'b1, hiz: 1'b1};
               end
            end
            OP_HIZ: begin
               if (!(|trip) && en_s2_q) begin
                  op_q <= OP_RUN;
               end else if (!en_s2_q && !(|trip)) begin
                  op_q <= OP_OFF;
               end
            end
            default: op_q <= OP_OFF;
         endcase
      end
   end

   chk_hiz_on_hard: assert property (@(posedge core_clk) disable iff (rst)
      (clk_en && op_q == OP_RUN && hard_trip) |=> stage_q.hiz && stage_q.hs_on_n
      && stage_q.ls_on_n) else $error("hard fault did not tristate");
   chk_track_reset: assert property (@(posedge core_clk)
      $fell(rst) |-> !track_en_q) else $error("tracking on after reset");
   chk_target_min: assert property (@(posedge core_clk) disable iff (rst)
      (op_q == OP_RUN && track_en_q) |=> target_q <= vout_setting || !$stable(vout_setting)
      || $past(op_q) != OP_RUN) else $error("target above setting");
   chk_alert_mask: assert property (@(posedge core_clk) disable iff (rst)
      (clk_en && (status_q & ~alert_mask) != '0) |=> !alert_n_q)
      else $error("unmasked flag did not alert");
   chk_soft_ramp: assert property (@(posedge core_clk) disable iff (rst)
      (clk_en && op_q == OP_RUN && soft_trip && !hard_trip) |=> op_q == OP_RAMP)
      else $error("soft-off not entered");
   chk_sync_default: assert property (@(posedge core_clk)
      $fell(rst) |-> sync_dir_q == SYNC_OFF) else $error("sync not off");
endmodule : conv_supervisor

// ---- tb/cond_model.sv ----
// Purpose: Monitoring comparators and tracking source on the far side of the supervisor
// Assumes: Changed by the bench just after a rising edge
// Notes: Comparator levels only, no analog behaviour
`timescale 1ns/10ps
module cond_model
   import conv_sup_pkg::*;
(
   input wire logic core_clk,
   output logic [3:0] cmp_fault,
   output logic [NUM_COND-1:0] cmp_warn,
   output logic [VW-1:0] tracking_input
);
   initial begin
      cmp_fault = 4'h0;
      cmp_warn = 6'h00;
      // Above any setting so the internal set point governs
      tracking_input = 12'hFFF;
   end

   // Glitch of n cycles on one fault comparator
   task automatic pulse(input int idx, input int n);
      cmp_fault[idx] = 1'b1;
      repeat (n) @(posedge core_clk);
      #1 cmp_fault[idx] = 1'b0;
   endtask : pulse
endmodule : cond_model

// ---- tb/tb_conv_supervisor.sv ----
// Purpose: Self-checking bench for the converter supervisor
// Assumes: 100 MHz clock, one cycle of delay unit is 100 clocks
// Notes: Scenarios from t_hard_fault on restart from reset to clear latched state
`timescale 1ns/10ps
module tb_conv_supervisor;
   import conv_sup_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic enable_pin = 1'b1;
   logic [VW-1:0] vout_setting = 12'h400;
   logic [VW-1:0] prebias_off_level = 12'h100;
   logic [7:0] fall_step = 8'h10;
   logic feature_control_command = 1'b0;
   logic [1:0] pin_configuration_command = 2'h0;
   logic cmd_strobe = 1'b0;
   logic [CW-1:0] iout_sample = 12'h000;
   logic iout_vld = 1'b0;
   logic signed [TW-1:0] ctrl_temp = 10'sd25;
   logic signed [TW-1:0] pt_temp_a = 10'sd25;
   logic signed [TW-1:0] pt_temp_b = 10'sd25;
   logic [NUM_COND-1:0] alert_mask = 6'h00;
   fault_cfg_t [NUM_COND-1:0] cfg = '0;
   logic status_clear = 1'b0;
   logic [3:0] cmp_fault;
   logic [NUM_COND-1:0] cmp_warn;
   logic [VW-1:0] tracking_input;
   logic [VW-1:0] target_q;
   stage_ctl_t stage_q;
   logic [1:0] sync_dir_q;
   logic signed [TW-1:0] temp_ctrl_q;
   logic signed [TW-1:0] temp_pt_q;
   logic [CW-1:0] iout_avg_q;
   logic [NUM_COND-1:0] status_q;
   logic alert_n_q;
   logic latched_off_q;
   int err_count = 0;
   int total_checks = 0;

   always #5 core_clk = ~core_clk;

   cond_model i_cond_model (.core_clk(core_clk), .cmp_fault(cmp_fault),
      .cmp_warn(cmp_warn), .tracking_input(tracking_input));

   conv_supervisor i_conv_supervisor (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
      .enable_pin(enable_pin), .vout_setting(vout_setting), .tracking_input(tracking_input),
      .prebias_off_level(prebias_off_level), .fall_step(fall_step),
      .feature_control_command(feature_control_command),
      .pin_configuration_command(pin_configuration_command), .cmd_strobe(cmd_strobe),
      .iout_sample(iout_sample), .iout_vld(iout_vld), .oc_fault_limit(12'h800),
      .oc_warn_limit(12'h700), .ctrl_temp(ctrl_temp), .pt_temp_a(pt_temp_a),
      .pt_temp_b(pt_temp_b), .ot_fault_limit(10'sd120), .cmp_fault(cmp_fault),
      .cmp_warn(cmp_warn), .alert_mask(alert_mask), .fault_cfg(cfg),
      .status_clear(status_clear), .target_q(target_q), .stage_q(stage_q),
      .sync_dir_q(sync_dir_q), .temp_ctrl_q(temp_ctrl_q), .temp_pt_q(temp_pt_q),
      .iout_avg_q(iout_avg_q), .status_q(status_q), .alert_n_q(alert_n_q),
      .latched_off_q(latched_off_q));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc

   task automatic results;
      if (err_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   // Fresh start; default fault handling except over-temperature soft-off
   task automatic restart;
      cfg = '0;
      cfg[IDX_OT].soft_off = 1'b1;
      rst = 1'b1;
      cyc(12);
      rst = 1'b0;
      cyc(8);
   endtask : restart

   task automatic send_cmd(input logic trk, input logic [1:0] pin);
      feature_control_command = trk;
      pin_configuration_command = pin;
      cmd_strobe = 1'b1;
      cyc(1);
      cmd_strobe = 1'b0;
      cyc(8);
   endtask : send_cmd

   task automatic t_reset_and_track;
      check("status", status_q, 6'h00);
      check("alert_n", alert_n_q, 1'b1);
      check("sync", sync_dir_q, 2'h0);
      i_cond_model.tracking_input = 12'h200;
      cyc(8);
      check("target_no_track", target_q, 12'h400);
      send_cmd(1'b1, 2'h0);
      check("target_track_low", target_q, 12'h200);
      i_cond_model.tracking_input = 12'hFFF;
      cyc(8);
      check("target_track_high", target_q, 12'h400);
      for (int m = 1; m < 3; m++) begin
         send_cmd(1'b1, m[1:0]);
         check("sync_dir", sync_dir_q, m);
      end
   endtask : t_reset_and_track

   task automatic t_temp_clamp;
      ctrl_temp = 10'sd100;
      pt_temp_a = -10'sd60;
      pt_temp_b = 10'sd0;
      cyc(6);
      check("temp_ctrl", 32'(temp_ctrl_q), 32'(10'sd100));
      check("temp_pt", 32'(temp_pt_q), 32'(TEMP_MIN));
      pt_temp_a = 10'sd25;
      pt_temp_b = 10'sd25;
   endtask : t_temp_clamp

   // Hard fault, masked alert on a second run, latch cleared by enable cycle
   task automatic t_hard_fault(input logic mask);
      restart();
      alert_mask = {5'h00, mask};
      check("stage_run", stage_q.hiz, 1'b0);
      i_cond_model.pulse(IDX_OUT_OV, 1);
      cyc(4);
      check("status_ov", status_q[IDX_OUT_OV], 1'b1);
      check("stage_hiz", stage_q, 3'b111);
      check("latched", latched_off_q, 1'b1);
      check("alert_n", alert_n_q, mask);
      enable_pin = 1'b0;
      cyc(6);
      enable_pin = 1'b1;
      cyc(20);
      check("unlatched", latched_off_q, 1'b0);
      alert_mask = 6'h00;
   endtask : t_hard_fault

   task automatic t_warning;
      restart();
      i_cond_model.cmp_warn[IDX_OUT_UV] = 1'b1;
      cyc(4);
      i_cond_model.cmp_warn[IDX_OUT_UV] = 1'b0;
      check("warn_flag", status_q[IDX_OUT_UV], 1'b1);
      check("warn_alert", alert_n_q, 1'b0);
      check("warn_stage", stage_q.hiz, 1'b0);
      check("warn_latch", latched_off_q, 1'b0);
   endtask : t_warning

   task automatic t_delay_to_fault;
      restart();
      cfg[IDX_IN_OV].delay_to_fault = 16'h0001;
      i_cond_model.pulse(IDX_IN_OV, 40);
      // Start just after a timebase tick so one whole delay unit elapses
      cyc(52);
      check("glitch_stage", stage_q.hiz, 1'b0);
      i_cond_model.cmp_fault[IDX_IN_OV] = 1'b1;
      cyc(85);
      check("delay_wait", stage_q.hiz, 1'b0);
      cyc(30);
      check("delay_trip", stage_q.hiz, 1'b1);
      i_cond_model.cmp_fault[IDX_IN_OV] = 1'b0;
   endtask : t_delay_to_fault

   task automatic t_retry(input logic [2:0] lim, input logic exp_latch);
      restart();
      cfg[IDX_IN_UV].delay_to_retry = 16'h0001;
      cfg[IDX_IN_UV].retry_limit = lim;
      i_cond_model.cmp_fault[IDX_IN_UV] = 1'b1;
      cyc(700);
      check("retry_latch", latched_off_q, exp_latch);
      i_cond_model.cmp_fault[IDX_IN_UV] = 1'b0;
      cyc(300);
      check("retry_resume", stage_q.hiz, exp_latch);
   endtask : t_retry

   task automatic t_oc_raw;
      restart();
      iout_sample = 12'h900;
      iout_vld = 1'b1;
      cyc(1);
      iout_vld = 1'b0;
      iout_sample = 12'h000;
      cyc(4);
      check("oc_trip", status_q[IDX_OC], 1'b1);
      check("oc_stage", stage_q.hiz, 1'b1);
      check("oc_avg_low", iout_avg_q < 12'h700, 1'b1);
   endtask : t_oc_raw

   task automatic t_soft_off;
      restart();
      pt_temp_a = 10'sd130;
      cyc(4);
      check("ot_flag", status_q[IDX_OT], 1'b1);
      check("ot_ramping", stage_q.hiz, 1'b0);
      cyc(120);
      check("ot_floor", target_q, 12'h100);
      check("ot_tristate", stage_q.hiz, 1'b1);
      pt_temp_a = 10'sd25;
   endtask : t_soft_off

   initial begin
      #200000;
      err_count++;
      results();
   end

   initial begin
      restart();
      t_reset_and_track();
      t_temp_clamp();
      t_hard_fault(1'b0);
      t_hard_fault(1'b1);
      t_warning();
      t_delay_to_fault();
      t_retry(3'h1, 1'b1);
      t_retry(RETRY_HICCUP, 1'b0);
      t_oc_raw();
      t_soft_off();
      results();
   end
endmodule : tb_conv_supervisor
